// ==== logic/omcc_ctrl.sv ====
// Operating-mode controller with APB registers and clock enables.
`timescale 1ns/1ps
`default_nettype none
module omcc_ctrl #(
	parameter int PORT_W = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic halt_exec,
	input wire logic clear_wdt_exec,
	input wire logic sub_clock_tick,
	input wire logic high_osc_ready,
	input wire logic low_osc_ready,
	input wire logic [PORT_W-1:0] port_pins,
	input wire logic sys_irq,
	input wire logic wdt_overflow,
	output logic fast_osc_enable,
	output logic cpu_clock_enable,
	output logic sys_clock_enable,
	output logic time_base_enable,
	output logic fast_div16_enable,
	output logic fast_div64_enable,
	output logic watchdog_clock_enable,
	output logic watchdog_clear,
	output logic cpu_halted,
	output logic powerdown_flag,
	output logic timeout_flag,
	output logic irq
);
	import omcc_pkg::*;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic wants_sub(input logic hsel, input logic [2:0] div);
		// With the high clock select bit clear, codes 000 and 001 pick sub.
		wants_sub = !hsel && (div <= OMCC_DIV_SUB_MAX);
	endfunction

	function automatic logic [OMCC_SHIFT_W-1:0] div_shift(input logic hsel,
		input logic [2:0] div);
		if (hsel || wants_sub(hsel, div))
			div_shift = '0;
		else
			div_shift = OMCC_SHIFT_W'(OMCC_DIV_SHIFT_BASE - {1'b0, div});
	endfunction

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic [2:0] clock_divide_select_r;
	logic high_clock_select_r;
	logic idle_enable_r;
	logic idle_clock_keep_r;
	logic [PORT_W-1:0] wake_enable_r;
	logic [OMCC_IRQ_W-1:0] irq_status_r;
	logic [OMCC_IRQ_W-1:0] irq_mask_r;
	logic [PORT_W-1:0] port_prev_r;
	logic powerdown_flag_r;
	logic timeout_flag_r;
	logic watchdog_clear_r;
	omcc_mode_t mode_r;
	omcc_mode_t mode_nxt;
	logic [31:0] prdata_r;
	logic wr;
	logic rd;
	logic mapped;
	logic sub_sel;
	logic fast_tick;
	logic sys_tick;
	logic lp_entry;
	logic wake_ev;
	logic [OMCC_TAP_W-1:0] tap_r;
	logic [OMCC_IRQ_W-1:0] events;

	assign wr = psel && penable && pwrite;
	assign rd = psel && penable && !pwrite;
	assign mapped = (paddr == OMCC_MODE_CTRL_OFF) || (paddr == OMCC_STATUS_OFF) ||
		(paddr == OMCC_IRQ_STATUS_OFF) || (paddr == OMCC_IRQ_MASK_OFF);
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign prdata = prdata_r;
	assign sub_sel = wants_sub(high_clock_select_r, clock_divide_select_r);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clock_divide_select_r <= OMCC_DIV_RST;
			high_clock_select_r <= OMCC_HSEL_RST;
			idle_enable_r <= 1'b0;
			idle_clock_keep_r <= 1'b0;
			wake_enable_r <= '0;
			irq_mask_r <= '0;
		end else if (wr && paddr == OMCC_MODE_CTRL_OFF) begin
			clock_divide_select_r <= pwdata[OMCC_DIV_LSB +: OMCC_DIV_W];
			high_clock_select_r <= pwdata[OMCC_HSEL_BIT];
			idle_enable_r <= pwdata[OMCC_IDLE_EN_BIT];
			idle_clock_keep_r <= pwdata[OMCC_KEEP_BIT];
			wake_enable_r <= pwdata[OMCC_WAKE_LSB +: PORT_W];
		end else if (wr && paddr == OMCC_IRQ_MASK_OFF) begin
			irq_mask_r <= pwdata[OMCC_IRQ_W-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= '0;
		end else if (psel && !penable && !pwrite) begin
			prdata_r <= '0;
			case (paddr)
				OMCC_MODE_CTRL_OFF: begin
					prdata_r[OMCC_DIV_LSB +: OMCC_DIV_W] <= clock_divide_select_r;
					prdata_r[OMCC_HSEL_BIT] <= high_clock_select_r;
					prdata_r[OMCC_IDLE_EN_BIT] <= idle_enable_r;
					prdata_r[OMCC_KEEP_BIT] <= idle_clock_keep_r;
					prdata_r[OMCC_WAKE_LSB +: PORT_W] <= wake_enable_r;
				end
				OMCC_STATUS_OFF: begin
					prdata_r[OMCC_LRDY_BIT] <= low_osc_ready;
					prdata_r[OMCC_HRDY_BIT] <= high_osc_ready;
					prdata_r[OMCC_PDF_BIT] <= powerdown_flag_r;
					prdata_r[OMCC_TOF_BIT] <= timeout_flag_r;
					prdata_r[OMCC_STATE_LSB +: 6] <= mode_r;
				end
				OMCC_IRQ_STATUS_OFF: prdata_r[OMCC_IRQ_W-1:0] <= irq_status_r;
				OMCC_IRQ_MASK_OFF: prdata_r[OMCC_IRQ_W-1:0] <= irq_mask_r;
				default: prdata_r <= '0;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Mode sequencing
	// ------------------------------------------------------------
	// Wake sources.
	assign wake_ev = sys_irq || wdt_overflow || |(wake_enable_r & port_prev_r & ~port_pins);
	assign lp_entry = halt_exec && (mode_r == OMCC_FAST || mode_r == OMCC_SLOW);

	always_comb begin
		mode_nxt = mode_r;
		case (mode_r)
			OMCC_FAST, OMCC_SLOW: begin
				if (halt_exec) begin
					if (!idle_enable_r)
						mode_nxt = OMCC_SLEEP;
					else if (!idle_clock_keep_r)
						mode_nxt = OMCC_IDLE_OFF;
					else
						mode_nxt = OMCC_IDLE_ON;
				end else if (mode_r == OMCC_FAST && sub_sel && low_osc_ready) begin
					mode_nxt = OMCC_SLOW;
				end else if (mode_r == OMCC_SLOW && !sub_sel && high_osc_ready) begin
					mode_nxt = OMCC_FAST;
				end
			end
			OMCC_SLEEP, OMCC_IDLE_OFF, OMCC_IDLE_ON: begin
				if (wake_ev)
					mode_nxt = OMCC_WAKE;
			end
			OMCC_WAKE: begin
				if (sub_sel && low_osc_ready)
					mode_nxt = OMCC_SLOW;
				else if (!sub_sel && high_osc_ready)
					mode_nxt = OMCC_FAST;
			end
			default: mode_nxt = OMCC_FAST;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			mode_r <= OMCC_FAST;
		else
			mode_r <= mode_nxt;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			port_prev_r <= '0;
		else
			port_prev_r <= port_pins;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			watchdog_clear_r <= 1'b0;
		else
			watchdog_clear_r <= lp_entry || clear_wdt_exec;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			powerdown_flag_r <= 1'b0;
			timeout_flag_r <= 1'b0;
		end else begin
			if (lp_entry)
				powerdown_flag_r <= 1'b1;
			else if (clear_wdt_exec)
				powerdown_flag_r <= 1'b0;
			if (wdt_overflow)
				timeout_flag_r <= 1'b1;
			else if (lp_entry)
				timeout_flag_r <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Clock enables
	// ------------------------------------------------------------
	// Fast oscillator off on sub.
	assign fast_osc_enable = (mode_r == OMCC_FAST) ||
		((mode_r == OMCC_SLOW || mode_r == OMCC_WAKE) && !sub_sel) ||
		(mode_r == OMCC_IDLE_ON && !sub_sel);

	omcc_divider #(
		.SHIFT_W(OMCC_SHIFT_W)
	) u_div (
		.pclk(pclk),
		.presetn(presetn),
		.run(fast_osc_enable),
		.shift(div_shift(high_clock_select_r, clock_divide_select_r)),
		.tick(fast_tick)
	);

	// Taps stop with the oscillator, which peripherals using them must tolerate.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			tap_r <= '0;
		else if (!fast_osc_enable)
			tap_r <= '0;
		else
			tap_r <= tap_r + 1'b1;
	end
	assign fast_div16_enable = fast_osc_enable && ((tap_r & OMCC_TAP16_MASK) == OMCC_TAP16_MASK);
	assign fast_div64_enable = fast_osc_enable && (tap_r == OMCC_TAP64_MASK);

	assign sys_tick = (mode_r == OMCC_SLOW || (mode_r == OMCC_IDLE_ON && sub_sel)) ?
		sub_clock_tick : (fast_tick && mode_r != OMCC_WAKE);
	assign cpu_halted = !(mode_r == OMCC_FAST || mode_r == OMCC_SLOW);
	assign cpu_clock_enable = sys_tick && !cpu_halted;
	assign sys_clock_enable = sys_tick && (mode_r != OMCC_SLEEP && mode_r != OMCC_IDLE_OFF);
	assign time_base_enable = (mode_r == OMCC_IDLE_OFF) ? sub_clock_tick :
		(sys_tick && mode_r != OMCC_SLEEP);
	assign watchdog_clock_enable = sub_clock_tick;
	assign watchdog_clear = watchdog_clear_r;
	assign powerdown_flag = powerdown_flag_r;
	assign timeout_flag = timeout_flag_r;

	// ------------------------------------------------------------
	// Interrupts
	// ------------------------------------------------------------
	assign events = {wdt_overflow && cpu_halted, mode_r == OMCC_WAKE && mode_nxt != OMCC_WAKE,
		lp_entry};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			irq_status_r <= '0;
		else if (rd && paddr == OMCC_IRQ_STATUS_OFF)
			// Only bits that this read reported are cleared, so a setup-cycle event survives.
			irq_status_r <= (irq_status_r & ~prdata_r[OMCC_IRQ_W-1:0]) | events;
		else
			irq_status_r <= irq_status_r | events;
	end

	assign irq = |(irq_status_r & irq_mask_r);
endmodule // omcc_ctrl
`default_nettype wire

// ==== logic/omcc_pkg.sv ====
// Constants for the operating-mode and system-clock controller.
// Summary of operation
// - Fast mode divides fast clock by 1 to 64.
// - Slow mode runs on sub clock, fast off.
// - Stop with idle disabled enters sleep mode.
// - Stop, idle enabled, no keep: clock-off idle.
// - Stop, idle enabled, keep: clock-on idle mode.
// - Sub clock chosen stops fast osc and taps.
// - Slow switch waits for slow oscillator ready.
// - Fast return waits for fast oscillator ready.
// - Sleep stops system and time base clocks.
// - Clock-off idle keeps time base and sub.
// - Clock-on idle keeps all clocks, CPU held.
// - Low-power entry retains memory, registers, ports.
// - Low-power entry clears and restarts watchdog.
// - Entry sets powerdown flag, clears timeout flag.
// - Wake on port fall, interrupt, watchdog overflow.
// - Wake to fast waits fast oscillator ready.
package omcc_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [11:0] OMCC_MODE_CTRL_OFF = 12'h000;
	localparam logic [11:0] OMCC_STATUS_OFF = 12'h004;
	localparam logic [11:0] OMCC_IRQ_STATUS_OFF = 12'h008;
	localparam logic [11:0] OMCC_IRQ_MASK_OFF = 12'h00C;

	// ------------------------------------------------------------
	// Field layout
	// ------------------------------------------------------------
	localparam int OMCC_DIV_LSB = 0;
	localparam int OMCC_DIV_W = 3;
	localparam int OMCC_HSEL_BIT = 3;
	localparam int OMCC_IDLE_EN_BIT = 4;
	localparam int OMCC_KEEP_BIT = 5;
	localparam int OMCC_WAKE_LSB = 8;
	localparam int OMCC_LRDY_BIT = 0;
	localparam int OMCC_HRDY_BIT = 1;
	localparam int OMCC_PDF_BIT = 2;
	localparam int OMCC_TOF_BIT = 3;
	localparam int OMCC_STATE_LSB = 4;
	localparam int OMCC_IRQ_W = 3;
	localparam int OMCC_EV_ENTRY = 0;
	localparam int OMCC_EV_WAKE = 1;
	localparam int OMCC_EV_TIMEOUT = 2;

	// ------------------------------------------------------------
	// Reset values and divider codes
	// ------------------------------------------------------------
	localparam logic [2:0] OMCC_DIV_RST = 3'h0;
	localparam logic OMCC_HSEL_RST = 1'b1;
	localparam logic [2:0] OMCC_DIV_SUB_MAX = 3'h1;
	localparam logic [3:0] OMCC_DIV_SHIFT_BASE = 4'h8;
	localparam int OMCC_SHIFT_W = 3;
	localparam int OMCC_TAP_W = 6;
	localparam logic [5:0] OMCC_TAP16_MASK = 6'h0F;
	localparam logic [5:0] OMCC_TAP64_MASK = 6'h3F;

	// ------------------------------------------------------------
	// Operating modes
	// ------------------------------------------------------------
	typedef enum logic [5:0] {
		OMCC_FAST = 6'b00_0001,
		OMCC_SLOW = 6'b00_0010,
		OMCC_SLEEP = 6'b00_0100,
		OMCC_IDLE_OFF = 6'b00_1000,
		OMCC_IDLE_ON = 6'b01_0000,
		OMCC_WAKE = 6'b10_0000
	} omcc_mode_t;

endpackage

// ==== logic/omcc_divider.sv ====
// Glitch-free power-of-two clock enable divider.
`timescale 1ns/1ps
`default_nettype none
module omcc_divider #(
	parameter int SHIFT_W = 3
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic run,
	input wire logic [SHIFT_W-1:0] shift,
	output logic tick
);
	logic [(1<<SHIFT_W)-2:0] cnt_r;
	logic [SHIFT_W-1:0] shift_r;
	logic [(1<<SHIFT_W)-2:0] last;
	localparam int CNT_W = (1 << SHIFT_W) - 1;

	// The ratio is only taken over at a period boundary, so a change never cuts a pulse short.
	assign last = CNT_W'((1 << shift_r) - 1);
	assign tick = run && (cnt_r == last);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= '0;
			shift_r <= '0;
		end else if (!run) begin
			cnt_r <= '0;
			shift_r <= shift;
		end else if (cnt_r == last) begin
			cnt_r <= '0;
			shift_r <= shift;
		end else begin
			cnt_r <= cnt_r + 1'b1;
		end
	end
endmodule // omcc_divider
`default_nettype wire

// ==== tb/omcc_ctrl_assertions.sv ====
// Port checker for the operating-mode controller.
`timescale 1ns/1ps
`default_nettype none
module omcc_ctrl_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic halt_exec,
	input wire logic sub_clock_tick,
	input wire logic high_osc_ready,
	input wire logic wdt_overflow,
	input wire logic fast_osc_enable,
	input wire logic cpu_clock_enable,
	input wire logic sys_clock_enable,
	input wire logic time_base_enable,
	input wire logic fast_div16_enable,
	input wire logic fast_div64_enable,
	input wire logic watchdog_clock_enable,
	input wire logic watchdog_clear,
	input wire logic cpu_halted,
	input wire logic powerdown_flag,
	input wire logic timeout_flag
);
	logic [5:0] ctl_r;
	logic run;
	assign run = halt_exec && !cpu_halted;
	// Shadow of the mode bits, so stop decoding can be judged from the ports alone.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl_r <= 6'h08;
		end else if (psel && penable && pwrite && paddr == 12'h000) begin
			ctl_r <= pwdata[5:0];
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_halt_wdt_clear: assert property (run |=> watchdog_clear)
		else $error("watchdog not cleared on stop");
	chk_halt_flags: assert property (run && !wdt_overflow |=> powerdown_flag && !timeout_flag)
		else $error("status flags wrong after stop");
	chk_sleep_clocks: assert property (run && !ctl_r[4] |=> cpu_halted && !sys_clock_enable && !time_base_enable)
		else $error("clocks running in sleep");
	chk_idle_off_osc: assert property (run && ctl_r[5:4] == 2'b01 |=> !sys_clock_enable && !fast_osc_enable)
		else $error("oscillator running in clock-off idle");
	chk_idle_on_osc: assert property (run && ctl_r[5:3] == 3'b111 |=> cpu_halted && fast_osc_enable)
		else $error("oscillator stopped in clock-on idle");
	chk_halted_no_cpu: assert property (cpu_halted |-> !cpu_clock_enable)
		else $error("cpu clocked while halted");
	chk_wake_hrdy: assert property (cpu_halted && !high_osc_ready && ctl_r[3] |=> cpu_halted)
		else $error("cpu resumed before fast oscillator ready");
	chk_taps_off: assert property (!fast_osc_enable |-> !fast_div16_enable && !fast_div64_enable)
		else $error("fast taps running with oscillator off");
	chk_wdt_clock: assert property (watchdog_clock_enable == sub_clock_tick)
		else $error("watchdog clock not following sub clock");
	cover property (run && !ctl_r[4]);
	cover property (run && ctl_r[5:4] == 2'b01);
	cover property (run && ctl_r[5:4] == 2'b11);
endmodule // omcc_ctrl_chk
bind omcc_ctrl omcc_ctrl_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.halt_exec, .sub_clock_tick, .high_osc_ready, .wdt_overflow, .fast_osc_enable,
	.cpu_clock_enable, .sys_clock_enable, .time_base_enable, .fast_div16_enable,
	.fast_div64_enable, .watchdog_clock_enable, .watchdog_clear, .cpu_halted,
	.powerdown_flag, .timeout_flag);
`default_nettype wire

// ==== tb/omcc_core_model.sv ====
// Behavioural core and oscillator side of the controller.
`timescale 1ns/1ps
`default_nettype none
module omcc_core_model #(
	parameter int SUB_DIV = 4,
	parameter int HRDY_DLY = 6
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic halt_req,
	input wire logic fast_osc_enable,
	output logic halt_exec,
	output logic sub_clock_tick,
	output logic high_osc_ready,
	output logic low_osc_ready
);
	int sub_cnt;
	int hcnt;
	// ready flags.
	// The fast oscillator restarts cold, so its ready flag lags the enable.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sub_cnt <= 0;
			hcnt <= 0;
			halt_exec <= 1'b0;
			sub_clock_tick <= 1'b0;
			high_osc_ready <= 1'b0;
			low_osc_ready <= 1'b0;
		end else begin
			halt_exec <= halt_req;
			sub_cnt <= (sub_cnt == SUB_DIV - 1) ? 0 : sub_cnt + 1;
			sub_clock_tick <= (sub_cnt == SUB_DIV - 1);
			low_osc_ready <= 1'b1;
			hcnt <= fast_osc_enable ? ((hcnt < HRDY_DLY) ? hcnt + 1 : hcnt) : 0;
			high_osc_ready <= fast_osc_enable && hcnt >= HRDY_DLY;
		end
	end
endmodule // omcc_core_model
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench for the operating-mode controller.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import omcc_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, halt_req, halt_exec;
	logic clear_wdt_exec, sys_irq, wdt_overflow, sub_clock_tick, high_osc_ready;
	logic low_osc_ready, fast_osc_enable, cpu_halted, powerdown_flag, timeout_flag, irq;
	logic cpu_clock_enable;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, e;
	logic [7:0] port_pins;
	logic [31:0] exp_q [$];
	logic [1:0] ki [3] = '{2'b00, 2'b01, 2'b11};
	omcc_mode_t mk [3] = '{OMCC_SLEEP, OMCC_IDLE_OFF, OMCC_IDLE_ON};
	int mismatches, n_compared, seed, k, n;
	omcc_ctrl uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr(), .halt_exec, .clear_wdt_exec, .sub_clock_tick, .high_osc_ready,
		.low_osc_ready, .port_pins, .sys_irq, .wdt_overflow, .fast_osc_enable,
		.cpu_clock_enable, .sys_clock_enable(), .time_base_enable(), .fast_div16_enable(),
		.fast_div64_enable(), .watchdog_clock_enable(), .watchdog_clear(), .cpu_halted,
		.powerdown_flag, .timeout_flag, .irq);
	omcc_core_model core (.pclk, .presetn, .halt_req, .fast_osc_enable, .halt_exec,
		.sub_clock_tick, .high_osc_ready, .low_osc_ready);
	task automatic chk(input logic [31:0] got, input logic [31:0] want);
		n_compared++;
		if (got !== want) begin
			mismatches++;
			$display("BAD at %0t: got %h want %h", $time, got, want);
		end
	endtask
	task automatic report_and_stop;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] want);
		exp_q.push_back(want);
		apb(1'b0, a, 32'h0);
	endtask
	// Counts CPU clock pulses over a window, which is phase independent for whole periods.
	task automatic count_cpu(input int cycles, input int want);
		int c;
		c = 0;
		repeat (cycles) @(posedge pclk) c += cpu_clock_enable;
		chk(32'(c), 32'(want));
	endtask
	always @(posedge pclk) begin
		if (psel && penable && !pwrite && pready === 1'b1) begin
			chk(prdata, exp_q.pop_front());
		end
	end
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	initial begin
		#100000;
		mismatches++;
		report_and_stop();
	end
	initial begin
		seed = 32'h936e_018c;
		{psel, penable, pwrite, halt_req, clear_wdt_exec, sys_irq, wdt_overflow} = '0;
		paddr = 12'h0;
		pwdata = 32'h0;
		port_pins = 8'hff;
		presetn = 1'b0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		rd(OMCC_MODE_CTRL_OFF, 32'h0000_0008);
		rd(12'h010, 32'h0);
		rd(OMCC_IRQ_MASK_OFF, 32'h0);
		count_cpu(16, 16);
		$display("test reset done");
		apb(1'b1, OMCC_MODE_CTRL_OFF, 32'h1);
		for (n = 0; n < 50 && fast_osc_enable !== 1'b0; n++) @(posedge pclk);
		chk(32'(fast_osc_enable), 32'h0);
		rd(OMCC_STATUS_OFF, {22'h0, OMCC_SLOW, 4'h1});
		count_cpu(16, 4);
		apb(1'b1, OMCC_MODE_CTRL_OFF, 32'h2);
		for (n = 0; n < 50 && high_osc_ready !== 1'b1; n++) @(posedge pclk);
		chk(32'(high_osc_ready), 32'h1);
		rd(OMCC_STATUS_OFF, {22'h0, OMCC_FAST, 4'h3});
		count_cpu(128, 2);
		$display("test switch done");
		for (k = 0; k < 3; k++) begin
			e = {16'h0, 7'($random(seed)), 1'b1, 2'b00, ki[k], 1'b1, 3'($random(seed))};
			apb(1'b1, OMCC_MODE_CTRL_OFF, e);
			rd(OMCC_MODE_CTRL_OFF, e);
			apb(1'b1, OMCC_IRQ_MASK_OFF, 32'h1);
			@(posedge pclk) halt_req <= 1'b1;
			@(posedge pclk) halt_req <= 1'b0;
			for (n = 0; n < 20 && cpu_halted !== 1'b1; n++) @(posedge pclk);
			chk(32'(cpu_halted), 32'h1);
			@(posedge pclk);
			chk(32'(irq), 32'h1);
			rd(OMCC_STATUS_OFF, {22'h0, mk[k], (k == 2) ? 4'h7 : 4'h5});
			rd(OMCC_IRQ_STATUS_OFF, 32'h1);
			@(posedge pclk);
			chk(32'(irq), 32'h0);
			@(posedge pclk);
			sys_irq <= (k == 0);
			port_pins[0] <= (k != 1);
			wdt_overflow <= (k == 2);
			@(posedge pclk);
			sys_irq <= 1'b0;
			wdt_overflow <= 1'b0;
			for (n = 0; n < 50 && cpu_halted !== 1'b0; n++) @(posedge pclk);
			chk(32'(cpu_halted), 32'h0);
			port_pins[0] <= 1'b1;
			rd(OMCC_STATUS_OFF, {22'h0, OMCC_FAST, (k == 2) ? 4'hf : 4'h7});
			rd(OMCC_IRQ_STATUS_OFF, (k == 2) ? 32'h6 : 32'h2);
			$display("test halt %0d done", k);
		end
		@(posedge pclk) clear_wdt_exec <= 1'b1;
		@(posedge pclk) clear_wdt_exec <= 1'b0;
		@(posedge pclk);
		chk(32'(powerdown_flag), 32'h0);
		report_and_stop();
	end
endmodule // tb_top
`default_nettype wire
